// File: acr_pkg.sv
// Constants shared by the conversion-restart two-wire slave
// ----------------------------------------------------------------------------
// How it works
// - A write that was acknowledged and then closed by Stop drops the unread result and starts a new conversion.
// - A configuration byte written before that Stop is applied to the new conversion.
// - The device answers the global call address 1110111 with write as well as its own address.
// - A global call write arriving after the conversion has finished is acknowledged by pulling the data line low.
// - The Stop closing a global call loads a received byte and starts a new conversion.
// - A global call closed by Stop without a byte starts a conversion and keeps the stored rate.
// - The device answers its own address 0010100, where the direction bit is 1 for read and 0 for write.
// - During a conversion any matching address is refused by leaving the data line released.
// - The top bit of the written byte selects the slow rate when 1 and the fast rate when 0, and fast is the reset value.
// - After an acknowledged read the 16-bit result is shifted out MSB first, changing on falling clock edges.
// ----------------------------------------------------------------------------
package acr_pkg;
   localparam logic [6:0] OWN_ADDR = 7'h14;
   localparam logic [6:0] GCALL_ADDR = 7'h77;
   localparam int RATE_BIT = 7;
   localparam logic SLOW_RATE_RST = 1'b0;
   localparam logic [15:0] RESULT_RST = 16'h0000;
   localparam int RESULT_W = 16;
   // Conversion times in microseconds; fast rate 60 Hz, slow rate 30 Hz
   localparam int CLK_MHZ = 50;
   localparam int FAST_CONV_US = 16667;
   localparam int SLOW_CONV_US = 33333;
   localparam int FAST_CONV_CYC = FAST_CONV_US * CLK_MHZ;
   localparam int SLOW_CONV_CYC = SLOW_CONV_US * CLK_MHZ;
   typedef enum logic [2:0] {
      ACR_IDLE = 3'b000,
      ACR_ADDR = 3'b001,
      ACR_AACK = 3'b010,
      ACR_WDAT = 3'b011,
      ACR_DACK = 3'b100,
      ACR_RDAT = 3'b101,
      ACR_RACK = 3'b110,
      ACR_SKIP = 3'b111
   } acr_state_t;
endpackage : acr_pkg

// File: acr_conv.sv
// Conversion timer: busy period and result capture
`timescale 1ns/1ps
`default_nettype none
module acr_conv #(
   parameter int FAST_CYC = acr_pkg::FAST_CONV_CYC,
   parameter int SLOW_CYC = acr_pkg::SLOW_CONV_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic i_slow,
   input wire logic [15:0] i_sample,
   output logic o_busy,
   output logic [15:0] o_result
);
   logic [31:0] cnt_ff;
   logic busy_ff;
   logic [15:0] res_ff;
   assign o_busy = busy_ff;
   assign o_result = res_ff;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         // Reset starts a conversion, like power-up
         busy_ff <= 1'b1;
         cnt_ff <= 32'(FAST_CYC - 1);
      end else if (i_start) begin
         busy_ff <= 1'b1;
         cnt_ff <= i_slow ? 32'(SLOW_CYC - 1) : 32'(FAST_CYC - 1);
      end else if (busy_ff) begin
         if (cnt_ff == 32'h0000_0000) begin
            busy_ff <= 1'b0;
         end else begin
            cnt_ff <= cnt_ff - 32'h0000_0001;
         end
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         res_ff <= acr_pkg::RESULT_RST;
      end else if (busy_ff && cnt_ff == 32'h0000_0000 && !i_start) begin
         res_ff <= i_sample;
      end
   end
endmodule : acr_conv
`default_nettype wire

// File: acr_i2c_slave.sv
// Two-wire slave that restarts conversions on write-then-Stop and global call
`timescale 1ns/1ps
`default_nettype none
module acr_i2c_slave #(
   parameter int FAST_CYC = acr_pkg::FAST_CONV_CYC,
   parameter int SLOW_CYC = acr_pkg::SLOW_CONV_CYC
) (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic I_SCL,
   input wire logic I_SDA,
   input wire logic [15:0] I_SAMPLE,
   output logic O_SDA,
   output logic O_SDA_OE,
   output logic O_BUSY,
   output logic O_SLOW_RATE_SELECT
);
   // ------------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------------
   logic scl_m_ff, scl_s_ff, scl_d_ff;
   logic sda_m_ff, sda_s_ff, sda_d_ff;
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         scl_m_ff <= 1'b1;
         scl_s_ff <= 1'b1;
         scl_d_ff <= 1'b1;
         sda_m_ff <= 1'b1;
         sda_s_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_m_ff <= I_SCL;
         scl_s_ff <= scl_m_ff;
         scl_d_ff <= scl_s_ff;
         sda_m_ff <= I_SDA;
         sda_s_ff <= sda_m_ff;
         sda_d_ff <= sda_s_ff;
      end
   end
   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise = scl_s_ff && !scl_d_ff;
   assign scl_fall = !scl_s_ff && scl_d_ff;
   assign start_det = scl_s_ff && scl_d_ff && !sda_s_ff && sda_d_ff;
   assign stop_det = scl_s_ff && scl_d_ff && sda_s_ff && !sda_d_ff;

   // ------------------------------------------------------------------------
   // Transfer state
   // ------------------------------------------------------------------------
   acr_pkg::acr_state_t state_ff, nxt_state;
   logic [3:0] bit_ff;
   logic [7:0] shreg_ff;
   logic [15:0] rd_ff;
   logic wr_acked_ff, byte_got_ff, slow_ff, pend_slow_ff, conv_start_ff;
   logic sda_oe_ff;
   logic busy;
   logic [15:0] result;
   logic [7:0] rx_byte;
   logic own_hit, gc_hit, addr_ok;
   assign rx_byte = {shreg_ff[6:0], sda_s_ff};
   // Address is judged at the eighth falling SCL, when the whole byte sits in the shifter
   assign own_hit = shreg_ff[7:1] == acr_pkg::OWN_ADDR;
   assign gc_hit = shreg_ff[7:1] == acr_pkg::GCALL_ADDR && !shreg_ff[0];
   // acknowledge only once the conversion is over
   assign addr_ok = (own_hit || gc_hit) && !busy;

   acr_conv #(
      .FAST_CYC(FAST_CYC),
      .SLOW_CYC(SLOW_CYC)
   ) u_conv (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_start(conv_start_ff),
      .i_slow(slow_ff),
      .i_sample(I_SAMPLE),
      .o_busy(busy),
      .o_result(result)
   );

   always_comb begin
      nxt_state = state_ff;
      if (start_det) begin
         nxt_state = acr_pkg::ACR_ADDR;
      end else if (stop_det) begin
         nxt_state = acr_pkg::ACR_IDLE;
      end else if (scl_fall) begin
         // Ack waits for the eighth falling SCL: SDA moving under a high SCL reads as Start
         case (state_ff)
            acr_pkg::ACR_ADDR: begin
               if (bit_ff == 4'h8) begin
                  nxt_state = addr_ok ? acr_pkg::ACR_AACK : acr_pkg::ACR_SKIP;
               end
            end
            acr_pkg::ACR_AACK: begin
               nxt_state = shreg_ff[0] ? acr_pkg::ACR_RDAT : acr_pkg::ACR_WDAT;
            end
            acr_pkg::ACR_WDAT: begin
               if (bit_ff == 4'h8) begin
                  nxt_state = acr_pkg::ACR_DACK;
               end
            end
            acr_pkg::ACR_DACK: nxt_state = acr_pkg::ACR_SKIP;
            acr_pkg::ACR_RDAT: begin
               if (bit_ff == 4'h7) begin
                  nxt_state = acr_pkg::ACR_RACK;
               end
            end
            acr_pkg::ACR_RACK: nxt_state = acr_pkg::ACR_RDAT;
            default: nxt_state = state_ff;
         endcase
      end else if (scl_rise && state_ff == acr_pkg::ACR_RACK && sda_s_ff) begin
         // Master NAK ends the read
         nxt_state = acr_pkg::ACR_SKIP;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         state_ff <= acr_pkg::ACR_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Bit counter and receive shifter
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         bit_ff <= 4'h0;
         shreg_ff <= 8'h00;
      end else if (start_det) begin
         bit_ff <= 4'h0;
      end else if (scl_rise && (state_ff == acr_pkg::ACR_ADDR ||
                                state_ff == acr_pkg::ACR_WDAT)) begin
         shreg_ff <= rx_byte;
         bit_ff <= bit_ff + 4'h1;
      end else if (scl_fall && (state_ff == acr_pkg::ACR_AACK ||
                                state_ff == acr_pkg::ACR_DACK ||
                                state_ff == acr_pkg::ACR_RACK)) begin
         bit_ff <= 4'h0;
      end else if (scl_fall && state_ff == acr_pkg::ACR_RDAT) begin
         bit_ff <= bit_ff + 4'h1;
      end
   end

   // Write bookkeeping: acked write, received byte, pending rate
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         wr_acked_ff <= 1'b0;
         byte_got_ff <= 1'b0;
         pend_slow_ff <= acr_pkg::SLOW_RATE_RST;
      end else if (stop_det) begin
         wr_acked_ff <= 1'b0;
         byte_got_ff <= 1'b0;
      end else if (scl_fall && bit_ff == 4'h8 && state_ff == acr_pkg::ACR_ADDR
                   && addr_ok && !shreg_ff[0]) begin
         wr_acked_ff <= 1'b1;
      end else if (scl_rise && bit_ff == 4'h7 && state_ff == acr_pkg::ACR_WDAT) begin
         byte_got_ff <= 1'b1;
         pend_slow_ff <= rx_byte[acr_pkg::RATE_BIT];
      end
   end

   // Rate setting and conversion restart on Stop
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         slow_ff <= acr_pkg::SLOW_RATE_RST;
         conv_start_ff <= 1'b0;
      end else begin
         conv_start_ff <= 1'b0;
         if (stop_det && wr_acked_ff) begin
            conv_start_ff <= 1'b1;
            if (byte_got_ff) begin
               slow_ff <= pend_slow_ff;
            end
         end else if (scl_rise && state_ff == acr_pkg::ACR_RACK && sda_s_ff) begin
            // Result consumed; next conversion starts
            conv_start_ff <= 1'b1;
         end
      end
   end

   // Read shifter loads on address acknowledge, shifts on falling SCL
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         rd_ff <= acr_pkg::RESULT_RST;
      end else if (nxt_state == acr_pkg::ACR_AACK && state_ff == acr_pkg::ACR_ADDR) begin
         rd_ff <= result;
      end else if (scl_fall && (state_ff == acr_pkg::ACR_RDAT ||
                                (state_ff == acr_pkg::ACR_AACK && shreg_ff[0]) ||
                                state_ff == acr_pkg::ACR_RACK)) begin
         if (state_ff == acr_pkg::ACR_RDAT) begin
            rd_ff <= {rd_ff[14:0], 1'b0};
         end
      end
   end

   // Open-drain drive: low for ACK or a zero data bit
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         sda_oe_ff <= 1'b0;
      end else begin
         case (nxt_state)
            acr_pkg::ACR_AACK: sda_oe_ff <= 1'b1;
            acr_pkg::ACR_DACK: sda_oe_ff <= 1'b1;
            acr_pkg::ACR_RDAT: begin
               if (scl_fall) begin
                  sda_oe_ff <= state_ff == acr_pkg::ACR_RDAT ? !rd_ff[14] : !rd_ff[15];
               end
            end
            default: sda_oe_ff <= 1'b0;
         endcase
      end
   end

   assign O_SDA = 1'b0;
   assign O_SDA_OE = sda_oe_ff;

   logic busy_o_ff;
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         busy_o_ff <= 1'b1;
      end else begin
         busy_o_ff <= busy;
      end
   end
   assign O_BUSY = busy_o_ff;
   assign O_SLOW_RATE_SELECT = slow_ff;
endmodule : acr_i2c_slave
`default_nettype wire

// File: acr_i2c_chk.sv
// Port assertions for the restart slave
`timescale 1ns/1ps
`default_nettype none
module acr_chk #(
   parameter int FAST_CYC = 200,
   parameter int SLOW_CYC = 400
) (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic I_SCL,
   input wire logic I_SDA,
   input wire logic [15:0] I_SAMPLE,
   input wire logic O_SDA,
   input wire logic O_SDA_OE,
   input wire logic O_BUSY,
   input wire logic O_SLOW_RATE_SELECT
);
   // ----
   // Helpers
   // ----
   logic [3:0] stop_age_ff;
   int busy_len_ff;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   // Age saturates so an old Stop never excuses a late rate change
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         stop_age_ff <= 4'hF;
      end else if (I_SCL && $past(I_SCL) && I_SDA && !$past(I_SDA)) begin
         stop_age_ff <= 4'h0;
      end else if (stop_age_ff != 4'hF) begin
         stop_age_ff <= stop_age_ff + 4'h1;
      end
   end
   always_ff @(posedge I_CLK) begin
      busy_len_ff <= (I_RST_N && O_BUSY) ? busy_len_ff + 1 : 0;
   end
   sequence s_stop_seen; stop_age_ff <= 4'h8; endsequence
   sequence s_conv_begins; ##[0:3] O_BUSY; endsequence
   property p_sda_zero; O_SDA == 1'b0; endproperty
   a_sda_zero: assert property (p_sda_zero) else $error("sda value high");
   property p_oe_scl_low; $changed(O_SDA_OE) |-> !I_SCL; endproperty
   a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved, scl high");
   property p_ack_hold; $rose(O_SDA_OE) |=> O_SDA_OE [*3]; endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("pull too short");
   property p_busy_nak; O_BUSY [*4] |-> !O_SDA_OE; endproperty
   a_busy_nak: assert property (p_busy_nak) else $error("ack while busy");
   property p_rate_at_stop; $changed(O_SLOW_RATE_SELECT) |-> s_stop_seen; endproperty
   a_rate_at_stop: assert property (p_rate_at_stop) else $error("rate moved off stop");
   property p_rate_conv; $changed(O_SLOW_RATE_SELECT) |-> s_conv_begins; endproperty
   a_rate_conv: assert property (p_rate_conv) else $error("rate without start");
   property p_conv_fast;
      $fell(O_BUSY) && !O_SLOW_RATE_SELECT |-> busy_len_ff inside {[FAST_CYC-2:FAST_CYC+2]};
   endproperty
   a_conv_fast: assert property (p_conv_fast) else $error("fast length");
   property p_conv_slow;
      $fell(O_BUSY) && O_SLOW_RATE_SELECT |-> busy_len_ff inside {[SLOW_CYC-2:SLOW_CYC+2]};
   endproperty
   a_conv_slow: assert property (p_conv_slow) else $error("slow length");
endmodule : acr_chk
bind acr_i2c_slave acr_chk #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) acr_chk_i (
   .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_SCL(I_SCL), .I_SDA(I_SDA), .I_SAMPLE(I_SAMPLE),
   .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE), .O_BUSY(O_BUSY),
   .O_SLOW_RATE_SELECT(O_SLOW_RATE_SELECT));
`default_nettype wire

// File: acr_master.sv
// Two-wire bus master model for the restart slave
`timescale 1ns/1ps
`default_nettype none
module acr_master (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_oe,
   output logic [8:0] o_res,
   output logic o_res_vld
);
   // ----
   // Bus phases
   // ----
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
      o_res = 9'h000;
      o_res_vld = 1'b0;
   end
   // Ten clocks a half bit leaves room for the slave's synchroniser
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : wt
   task automatic start_c;
      o_sda_oe = 1'b1;
      wt(10);
      o_scl = 1'b0;
      wt(10);
   endtask : start_c
   task automatic stop_c;
      o_sda_oe = 1'b1;
      wt(10);
      o_scl = 1'b1;
      wt(10);
      o_sda_oe = 1'b0;
      wt(20);
   endtask : stop_c
   // Nine bits: wb then ak; every bit read back from the wire is reported
   task automatic byte_c(input logic [7:0] wb, input logic ak);
      logic [8:0] sh;
      sh = {wb, ak};
      for (int i = 8; i >= 0; i--) begin
         o_sda_oe = !sh[i];
         wt(10);
         o_scl = 1'b1;
         wt(5);
         o_res = {o_res[7:0], i_sda};
         wt(5);
         o_scl = 1'b0;
         wt(2);
      end
      o_res_vld = 1'b1;
      wt(1);
      o_res_vld = 1'b0;
   endtask : byte_c
endmodule : acr_master
`default_nettype wire

// File: acr_i2c_slave_test.sv
// Self-checking bench for the restart slave
`timescale 1ns/1ps
`default_nettype none
module acr_i2c_slave_test;
   // ----
   // Bench
   // ----
   // Fast time must outlast the first address byte after reset so the busy refusal is seen
   localparam int FAST = 400;
   localparam int SLOW = 800;
   logic clk, rst_n, oe, busy, rate, sda_val, m_scl, m_oe, vld;
   logic [15:0] sample, s2;
   logic [8:0] res;
   logic [8:0] exp_q[$];
   logic [8:0] gc[3] = '{9'h100, 9'h180, 9'h080};
   int num_errors = 0;
   int checked = 0;
   int cyc = 0;
   int seed = 94;
   wire sda = !(m_oe || (oe && !sda_val));
   acr_i2c_slave #(.FAST_CYC(FAST), .SLOW_CYC(SLOW)) acr_i2c_slave_i (
      .I_CLK(clk), .I_RST_N(rst_n), .I_SCL(m_scl), .I_SDA(sda), .I_SAMPLE(sample),
      .O_SDA(sda_val), .O_SDA_OE(oe), .O_BUSY(busy), .O_SLOW_RATE_SELECT(rate));
   acr_master acr_master_i (.i_clk(clk), .i_sda(sda), .o_scl(m_scl), .o_sda_oe(m_oe),
      .o_res(res), .o_res_vld(vld));
   initial begin
      clk = 1'b0;
      forever #10 clk = !clk;
   end
   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic xb(input logic [7:0] d, input logic ak, input logic [8:0] e);
      exp_q.push_back(e);
      acr_master_i.byte_c(d, ak);
   endtask : xb
   task automatic wr(input logic [7:0] d, input logic nak);
      xb(d, 1'b1, {d, nak});
   endtask : wr
   task automatic st(input logic b, input logic r);
      chk("busy", {8'h00, b}, {8'h00, busy});
      chk("rate", {8'h00, r}, {8'h00, rate});
   endtask : st
   task automatic idle;
      repeat (1000) if (busy !== 1'b0) acr_master_i.wt(1);
      acr_master_i.wt(4);
   endtask : idle
   task automatic test_done;
      $display("checked %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done
   always @(posedge clk) begin
      if (vld === 1'b1) begin
         chk("bus", exp_q.size() ? exp_q.pop_front() : 9'h1FF, res);
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         test_done();
      end
   end
   initial begin
      rst_n = 1'b0;
      sample = 16'($random(seed));
      s2 = 16'($random(seed));
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      acr_master_i.start_c();
      wr(8'h28, 1'b1);
      acr_master_i.stop_c();
      st(1'b1, 1'b0);
      idle();
      for (int i = 0; i < 2; i++) begin
         acr_master_i.start_c();
         wr(i ? 8'hEF : 8'hA0, 1'b1);
         acr_master_i.stop_c();
         st(1'b0, 1'b0);
      end
      $display("test refusals done");
      sample = s2;
      acr_master_i.start_c();
      wr(8'h28, 1'b0);
      wr(8'h80, 1'b0);
      acr_master_i.stop_c();
      st(1'b1, 1'b1);
      idle();
      acr_master_i.start_c();
      wr(8'h29, 1'b0);
      xb(8'hFF, 1'b0, {s2[15:8], 1'b0});
      xb(8'hFF, 1'b1, {s2[7:0], 1'b1});
      acr_master_i.stop_c();
      st(1'b1, 1'b1);
      $display("test restart and read done");
      for (int i = 0; i < 3; i++) begin
         idle();
         acr_master_i.start_c();
         wr(8'hEE, 1'b0);
         if (gc[i][8]) wr(gc[i][7:0], 1'b0);
         acr_master_i.stop_c();
         st(1'b1, gc[i][7]);
      end
      acr_master_i.start_c();
      wr(8'hEE, 1'b1);
      acr_master_i.stop_c();
      chk("left", 9'h000, 9'(exp_q.size()));
      $display("test global call done");
      test_done();
   end
endmodule : acr_i2c_slave_test
`default_nettype wire
